// ===== shared/pao_pkg.sv
package pao_pkg;

  localparam int PAO_N_DIN = 8;
  localparam int PAO_N_OUT = 8;
  localparam int PAO_N_IN = 16;
  localparam int PAO_N_LIT = 32;
  localparam int PAO_N_PT = 8;
  localparam int PAO_N_TIN = 4;
  localparam int PAO_N_TLIT = 8;
  localparam int PAO_N_TERMS = 64;

  localparam logic [11:0] PAO_CTRL_OFS = 12'h000;
  localparam logic [11:0] PAO_STAT_OFS = 12'h004;
  localparam logic [11:0] PAO_PRELOAD_OFS = 12'h008;
  localparam logic [3:0] PAO_NORM_PAGE = 4'h1;
  localparam logic [3:0] PAO_TEST_PAGE = 4'h2;

  localparam int PAO_CTRL_VAR_LSB = 0;
  localparam int PAO_CTRL_TEST_BIT = 2;
  localparam int PAO_CTRL_LOCK_BIT = 3;
  localparam int PAO_STAT_Q_LSB = 0;
  localparam int PAO_STAT_PIN_LSB = 8;
  localparam int PAO_STAT_REG_LSB = 16;

  localparam int PAO_R6_LO = 1;
  localparam int PAO_R6_HI = 6;
  localparam int PAO_R4_LO = 2;
  localparam int PAO_R4_HI = 5;
  localparam int PAO_L8_FB_LO = 1;
  localparam int PAO_L8_FB_HI = 6;

  typedef enum logic [1:0] {
    PAO_VAR_R8 = 2'h0,
    PAO_VAR_R6 = 2'h1,
    PAO_VAR_R4 = 2'h2,
    PAO_VAR_L8 = 2'h3
  } pao_variant_t;

  localparam pao_variant_t PAO_VAR_RST = PAO_VAR_R8;
  localparam logic [7:0] PAO_Q_RST = 8'h00;

  typedef struct packed {
    pao_variant_t variant;
    logic test_mode;
    logic lock;
  } pao_ctrl_t;

  typedef struct packed {
    pao_ctrl_t ctrl;
    logic [PAO_N_OUT-1:0] q;
  } pao_state_t;

  typedef struct packed {
    logic [PAO_N_OUT-1:0] o;
    logic [PAO_N_OUT-1:0] oe;
  } pao_pins_t;

  function automatic logic pao_is_reg(pao_variant_t v, int idx);
    case (v)
      PAO_VAR_R8: return 1'b1;
      PAO_VAR_R6: return (idx >= PAO_R6_LO) && (idx <= PAO_R6_HI);
      PAO_VAR_R4: return (idx >= PAO_R4_LO) && (idx <= PAO_R4_HI);
      default: return 1'b0;
    endcase
  endfunction

endpackage

// ===== src/pao_cell_mem.sv
`timescale 1ns/100ps
`default_nettype none
module pao_cell_mem import pao_pkg::*; #(
  parameter int W = 32,
  parameter int D = 64
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [$clog2(D)-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(D)-1:0] rd_addr,
  output logic [W-1:0] rd_data,
  output logic [D*W-1:0] cells
);

  typedef struct packed {
    logic [D*W-1:0] cells;
    logic [W-1:0] rd;
  } pao_mem_st_t;

  pao_mem_st_t st_reg;
  pao_mem_st_t st_next;

  if (W < 1 || D < 2) begin : g_chk
    $error("pao_cell_mem: bad geometry");
  end

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.cells[wr_addr*W +: W] = wr_data;
    end
    if (rd_en) begin
      st_next.rd = st_reg.cells[rd_addr*W +: W];
    end
  end

  // Erased cells are all zero, so every literal stays connected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd;
  assign cells = st_reg.cells;

endmodule
`default_nettype wire

// ===== src/pao_sop_cell.sv
`timescale 1ns/100ps
`default_nettype none
module pao_sop_cell import pao_pkg::*; #(
  parameter int NLIT = 32,
  parameter int NTLIT = 8,
  parameter int NPT = 8
) (
  input wire logic [NLIT-1:0] lits,
  input wire logic [NTLIT-1:0] tlits,
  input wire logic [NPT*NLIT-1:0] cells,
  input wire logic [NPT*NTLIT-1:0] tcells,
  input wire logic test_mode,
  output logic sum_all,
  output logic sum_rest,
  output logic en_term
);

  logic [NPT-1:0] pt;

  if (NPT < 2 || NLIT < 2 || NTLIT < 2) begin : g_chk
    $error("pao_sop_cell: bad geometry");
  end

  // A set cell lifts its literal out of the AND
  always_comb begin
    pt = '0;
    for (int k = 0; k < NPT; k++) begin
      if (test_mode) begin
        pt[k] = &(tlits | tcells[k*NTLIT +: NTLIT]); // [RULE10]
      end else begin
        pt[k] = &(lits | cells[k*NLIT +: NLIT]); // [RULE6] [RULE11]
      end
    end
  end

  assign sum_all = |pt; // [RULE5]
  assign en_term = pt[0]; // [RULE14]
  assign sum_rest = |pt[NPT-1:1]; // [RULE12]

endmodule
`default_nettype wire

// ===== src/pao_array_top.sv
// Function
// [RULE1] Four variants: R8, R6, R4, all-combinatorial
// [RULE2] Sixteen array inputs, eight outputs
// [RULE3] Disabled combinatorial outputs serve as inputs; in L8 only outputs 1 to 6 feed back, outputs 0 and 7 do not
// [RULE4] Registered outputs feed Q-bar back into array
// [RULE5] Outputs are AND terms into fixed OR
// [RULE6] Erased cell connects literal; programmed removes it
// [RULE7] Locked device hides normal array on readout
// [RULE8] Test array stays readable when locked
// [RULE9] Preload forces output flip-flops to chosen state
// [RULE10] Test mode uses only test literals
// [RULE11] Normal mode ignores test literals
// [RULE12] Registered: eight terms; combinatorial: seven, inverted
// [RULE13] Flip-flops capture term sum on clock rise
// [RULE14] One term drives each combinatorial output enable
// [RULE15] Shared active-low pin enables registered outputs
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module pao_array_top import pao_pkg::*; #(
  parameter int N_TIN = PAO_N_TIN
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PAO_N_DIN-1:0] din,
  input wire logic [N_TIN-1:0] test_in,
  input wire logic oe_n,
  input wire logic [PAO_N_OUT-1:0] io_i,
  output pao_pins_t io_drv
);

  if (N_TIN != PAO_N_TLIT / 2) begin : g_chk
    $error("pao_array_top: test input count must match test literals");
  end

  localparam int ROW = PAO_N_PT * PAO_N_LIT;
  localparam int TROW = PAO_N_PT * PAO_N_TLIT;
  localparam int AW = $clog2(PAO_N_TERMS);

  pao_state_t st_reg;
  pao_state_t st_next;

  logic acc;
  logic setup;
  logic aligned;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_pre;
  logic in_norm;
  logic in_test;
  logic mapped;
  logic rd_locked;
  logic pre_wr;
  logic [AW-1:0] word;

  logic [PAO_N_OUT-1:0] is_reg;
  logic [PAO_N_OUT-1:0] fb_ok;
  logic [PAO_N_OUT-1:0] fb;
  logic [PAO_N_IN-1:0] in_vec;
  logic [PAO_N_LIT-1:0] lits;
  logic [PAO_N_TLIT-1:0] tlits;

  logic [PAO_N_TERMS*PAO_N_LIT-1:0] norm_cells;
  logic [PAO_N_TERMS*PAO_N_TLIT-1:0] test_cells;
  logic [PAO_N_LIT-1:0] norm_rd;
  logic [PAO_N_TLIT-1:0] test_rd;

  logic [PAO_N_OUT-1:0] sum_all;
  logic [PAO_N_OUT-1:0] sum_rest;
  logic [PAO_N_OUT-1:0] en_term;

  // Bus decode
  assign acc = psel & penable;
  assign setup = psel & ~penable;
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_ctrl = (paddr == PAO_CTRL_OFS);
  assign hit_stat = (paddr == PAO_STAT_OFS);
  assign hit_pre = (paddr == PAO_PRELOAD_OFS);
  assign in_norm = (paddr[11:8] == PAO_NORM_PAGE) & aligned;
  assign in_test = (paddr[11:8] == PAO_TEST_PAGE) & aligned;
  assign mapped = hit_ctrl | hit_stat | hit_pre | in_norm | in_test;
  assign word = paddr[AW+1:2];
  assign pre_wr = acc & pwrite & hit_pre;

  // Verify readout of the normal array is refused once locked
  assign rd_locked = in_norm & ~pwrite & st_reg.ctrl.lock; // [RULE7]

  // Array reads are launched in setup, so every access ends at once
  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | rd_locked);

  // Output arrangement per variant
  always_comb begin
    is_reg = '0;
    fb_ok = '0;
    for (int i = 0; i < PAO_N_OUT; i++) begin
      is_reg[i] = pao_is_reg(st_reg.ctrl.variant, i); // [RULE1]
      if (st_reg.ctrl.variant == PAO_VAR_L8) begin
        fb_ok[i] = (i >= PAO_L8_FB_LO) && (i <= PAO_L8_FB_HI); // [RULE3]
      end else begin
        fb_ok[i] = !is_reg[i]; // [RULE3]
      end
    end
  end

  // Feedback: Q-bar from flip-flops, pin level from floated drivers
  always_comb begin
    fb = '0;
    for (int i = 0; i < PAO_N_OUT; i++) begin
      if (is_reg[i]) begin
        fb[i] = ~st_reg.q[i]; // [RULE4]
      end else if (fb_ok[i]) begin
        fb[i] = io_i[i]; // [RULE3]
      end else begin
        fb[i] = 1'b0;
      end
    end
  end

  assign in_vec = {fb, din}; // [RULE2]
  assign lits = {~in_vec, in_vec}; // [RULE6]
  assign tlits = {~test_in, test_in};

  pao_cell_mem #(
    .W(PAO_N_LIT),
    .D(PAO_N_TERMS)
  ) u_norm_mem (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(acc & pwrite & in_norm),
    .wr_addr(word),
    .wr_data(pwdata[PAO_N_LIT-1:0]),
    .rd_en(setup & ~pwrite & in_norm),
    .rd_addr(word),
    .rd_data(norm_rd),
    .cells(norm_cells)
  );

  pao_cell_mem #(
    .W(PAO_N_TLIT),
    .D(PAO_N_TERMS)
  ) u_test_mem (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(acc & pwrite & in_test),
    .wr_addr(word),
    .wr_data(pwdata[PAO_N_TLIT-1:0]),
    .rd_en(setup & ~pwrite & in_test),
    .rd_addr(word),
    .rd_data(test_rd),
    .cells(test_cells)
  );

  // One sum-of-products slice per output
  for (genvar g = 0; g < PAO_N_OUT; g++) begin : g_sop
    pao_sop_cell #(
      .NLIT(PAO_N_LIT),
      .NTLIT(PAO_N_TLIT),
      .NPT(PAO_N_PT)
    ) u_sop (
      .lits(lits),
      .tlits(tlits),
      .cells(norm_cells[g*ROW +: ROW]),
      .tcells(test_cells[g*TROW +: TROW]),
      .test_mode(st_reg.ctrl.test_mode), // [RULE10] [RULE11]
      .sum_all(sum_all[g]),
      .sum_rest(sum_rest[g]),
      .en_term(en_term[g])
    );
  end

  // Read data
  always_comb begin
    prdata = '0;
    if (acc & ~pwrite) begin
      if (hit_ctrl) begin
        prdata[PAO_CTRL_VAR_LSB +: 2] = st_reg.ctrl.variant;
        prdata[PAO_CTRL_TEST_BIT] = st_reg.ctrl.test_mode;
        prdata[PAO_CTRL_LOCK_BIT] = st_reg.ctrl.lock;
      end else if (hit_stat) begin
        prdata[PAO_STAT_Q_LSB +: PAO_N_OUT] = st_reg.q;
        prdata[PAO_STAT_PIN_LSB +: PAO_N_OUT] = io_i;
        prdata[PAO_STAT_REG_LSB +: PAO_N_OUT] = is_reg;
      end else if (hit_pre) begin
        prdata[PAO_N_OUT-1:0] = st_reg.q;
      end else if (in_norm && !st_reg.ctrl.lock) begin
        prdata[PAO_N_LIT-1:0] = norm_rd; // [RULE7]
      end else if (in_test) begin
        prdata[PAO_N_TLIT-1:0] = test_rd; // [RULE8]
      end
    end
  end

  // Next state
  always_comb begin
    st_next = st_reg;
    if (acc && pwrite && hit_ctrl) begin
      st_next.ctrl.variant = pao_variant_t'(pwdata[PAO_CTRL_VAR_LSB +: 2]);
      st_next.ctrl.test_mode = pwdata[PAO_CTRL_TEST_BIT];
      // Lock only sets; clearing it needs a full reset
      if (pwdata[PAO_CTRL_LOCK_BIT]) begin
        st_next.ctrl.lock = 1'b1; // [RULE7]
      end
    end
    if (pre_wr) begin
      st_next.q = pwdata[PAO_N_OUT-1:0]; // [RULE9]
    end else begin
      st_next.q = sum_all; // [RULE13] [RULE12]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.ctrl.variant <= PAO_VAR_RST;
      st_reg.ctrl.test_mode <= 1'b0;
      st_reg.ctrl.lock <= 1'b0;
      st_reg.q <= PAO_Q_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin drivers
  always_comb begin
    io_drv = '0;
    for (int i = 0; i < PAO_N_OUT; i++) begin
      if (is_reg[i]) begin
        io_drv.o[i] = ~st_reg.q[i]; // [RULE12]
        io_drv.oe[i] = ~oe_n; // [RULE15]
      end else begin
        io_drv.o[i] = ~sum_rest[i]; // [RULE12]
        io_drv.oe[i] = en_term[i]; // [RULE14]
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_reg_capture: assert property ( // [RULE13]
    !pre_wr |=> st_reg.q == $past(sum_all)
  ) else $error("flip-flops did not capture term sum");

  chk_preload_force: assert property ( // [RULE9]
    pre_wr |=> st_reg.q == $past(pwdata[7:0])
  ) else $error("preload value not taken");

  chk_reg_pin: assert property ( // [RULE12]
    ((io_drv.o ^ ~st_reg.q) & is_reg) == '0
  ) else $error("registered pin not inverted Q");

  chk_shared_enable: assert property ( // [RULE15]
    (io_drv.oe & is_reg) == ({PAO_N_OUT{~oe_n}} & is_reg)
  ) else $error("registered enable not from shared pin");

  chk_comb_enable: assert property ( // [RULE14]
    ((io_drv.oe ^ en_term) & ~is_reg) == '0 &&
    ((io_drv.o ^ ~sum_rest) & ~is_reg) == '0
  ) else $error("combinatorial pin not driven by its terms");

  chk_fb_qbar: assert property ( // [RULE4]
    ((fb ^ ~st_reg.q) & is_reg) == '0
  ) else $error("feedback is not Q-bar");

  chk_lock_hide: assert property ( // [RULE7]
    (acc && !pwrite && in_norm && st_reg.ctrl.lock) |->
      (prdata == '0) && pslverr
  ) else $error("locked array was read out");

  chk_lock_sticky: assert property ( // [RULE7]
    st_reg.ctrl.lock |=> st_reg.ctrl.lock [*3]
  ) else $error("lock released without reset");

  chk_test_open: assert property ( // [RULE8]
    (acc && !pwrite && in_test) |-> !pslverr &&
      prdata[PAO_N_TLIT-1:0] == test_rd
  ) else $error("test array read refused");

  chk_variant_count: assert property ( // [RULE1]
    $countones(is_reg) ==
      ((st_reg.ctrl.variant == PAO_VAR_R8) ? 8 :
       (st_reg.ctrl.variant == PAO_VAR_R6) ? 6 :
       (st_reg.ctrl.variant == PAO_VAR_R4) ? 4 : 0)
  ) else $error("registered output count wrong");

  chk_input_use: assert property ( // [RULE3]
    (st_reg.ctrl.variant == PAO_VAR_L8) |->
      $countones(fb_ok) == 6 && ((fb ^ io_i) & fb_ok) == '0
  ) else $error("floated output not usable as input");

  // Bus side: refusals, quiet idle and landed writes

  chk_bus_ready: assert property (
    pready
  ) else $error("bus wait state inserted");

  chk_unmapped_err: assert property (
    (acc && !mapped) |-> pslverr && (prdata == '0)
  ) else $error("unmapped access not refused");

  chk_idle_read: assert property (
    !(acc && !pwrite) |-> (prdata == '0)
  ) else $error("read data outside a read access");

  chk_idle_err: assert property (
    !acc |-> !pslverr
  ) else $error("error outside an access");

  chk_ctrl_write: assert property ( // [RULE1] [RULE10]
    (acc && pwrite && hit_ctrl) |=>
      (st_reg.ctrl.variant == $past(pwdata[1:0])) &&
      (st_reg.ctrl.test_mode == $past(pwdata[PAO_CTRL_TEST_BIT]))
  ) else $error("control write not taken");

  chk_lock_set: assert property ( // [RULE7]
    (acc && pwrite && hit_ctrl && pwdata[PAO_CTRL_LOCK_BIT]) |=>
      st_reg.ctrl.lock
  ) else $error("lock not set by write");

  chk_lock_only_write: assert property ( // [RULE7]
    (!st_reg.ctrl.lock && !(acc && pwrite && hit_ctrl)) |=>
      !st_reg.ctrl.lock
  ) else $error("lock set without a control write");

  chk_norm_write: assert property ( // [RULE6]
    (acc && pwrite && in_norm) |=>
      norm_cells[$past(word)*PAO_N_LIT +: PAO_N_LIT] == $past(pwdata)
  ) else $error("term word not stored");

  chk_test_write: assert property ( // [RULE10]
    (acc && pwrite && in_test) |=>
      test_cells[$past(word)*PAO_N_TLIT +: PAO_N_TLIT] ==
        $past(pwdata[PAO_N_TLIT-1:0])
  ) else $error("test term word not stored");

  chk_stat_mask: assert property ( // [RULE1]
    (acc && !pwrite && hit_stat) |->
      prdata[PAO_STAT_REG_LSB +: PAO_N_OUT] == is_reg
  ) else $error("status mask wrong");

endmodule
`default_nettype wire

// ===== verif/pao_board.sv
`timescale 1ns/100ps
`default_nettype none
module pao_board import pao_pkg::*; (
  input wire logic clk,
  input wire pao_pins_t io_drv,
  output logic [7:0] din,
  output logic [3:0] test_in,
  output logic oe_n,
  output logic [7:0] io_i
);
  integer seed = 32'h1BD1;
  logic [7:0] ext;
  initial begin
    din = 8'h00;
    test_in = 4'h0;
    oe_n = 1'b0;
    ext = 8'hA5;
  end
  // A released pin shows fresh noise, never the last driven level
  assign io_i = (io_drv.oe & io_drv.o) | (~io_drv.oe & ext);
  always @(posedge clk) begin
    din <= 8'($random(seed));
    test_in <= 4'($random(seed));
    oe_n <= 1'($random(seed));
    ext <= 8'($random(seed));
  end
endmodule
`default_nettype wire

// ===== verif/pao_array_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pao_array_top_tb import pao_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, oe_n;
  logic [7:0] din, io_i;
  logic [3:0] test_in;
  pao_pins_t io_drv;
  logic [31:0] mc [64];
  logic [7:0] mt [64];
  logic [7:0] mq;
  logic [1:0] mv;
  logic mtm, mlk;
  integer seed = 32'h1BD1;
  int n_fail = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  pao_array_top pao_array_top_i (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
    .test_in(test_in), .oe_n(oe_n), .io_i(io_i), .io_drv(io_drv));
  pao_board pao_board_i (.clk(clk), .io_drv(io_drv), .din(din),
    .test_in(test_in), .oe_n(oe_n), .io_i(io_i));

  function automatic logic isreg(int k);
    return mv == 2'h0 || (mv == 2'h1 && k >= PAO_R6_LO && k <= PAO_R6_HI)
      || (mv == 2'h2 && k >= PAO_R4_LO && k <= PAO_R4_HI);
  endfunction

  function automatic logic term(int t);
    logic [15:0] v = {8'h00, din};
    for (int k = 0; k < 8; k++)
      v[8+k] = isreg(k) ? ~mq[k] :
        (mv == 2'h3 && (k == 0 || k == 7)) ? 1'b0 : io_i[k];
    if (mtm) return ({~test_in, test_in} | mt[t]) == 8'hFF;
    return ({~v, v} | mc[t]) == 32'hFFFF_FFFF;
  endfunction

  function automatic logic orsum(int k, int lo);
    logic s = 1'b0;
    for (int p = lo; p < 8; p++) s |= term(k * 8 + p);
    return s;
  endfunction

  function automatic logic [32:0] mread(logic [11:0] a);
    logic [7:0] m = 8'h00;
    for (int k = 0; k < 8; k++) m[k] = isreg(k);
    if (a == PAO_CTRL_OFS) return {29'h0, mlk, mtm, mv};
    if (a == PAO_STAT_OFS) return {9'h0, m, io_i, mq};
    if (a == PAO_PRELOAD_OFS) return {25'h0, mq};
    if (a[1:0] != 2'h0) return {1'b1, 32'h0};
    if (a[11:8] == PAO_NORM_PAGE)
      return mlk ? {1'b1, 32'h0} : {1'b0, mc[a[7:2]]};
    if (a[11:8] == PAO_TEST_PAGE) return {25'h0, mt[a[7:2]]};
    return {1'b1, 32'h0};
  endfunction

  // Snoops the bus at the same edge that the device commits a write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mq = PAO_Q_RST;
      mv = 2'h0;
      mtm = 1'b0;
      mlk = 1'b0;
      for (int t = 0; t < 64; t++) begin
        mc[t] = 32'h0;
        mt[t] = 8'h00;
      end
    end else begin
      logic [7:0] nq;
      for (int k = 0; k < 8; k++) nq[k] = orsum(k, 0);
      if (psel && penable && pwrite) begin
        if (paddr == PAO_CTRL_OFS) begin
          mv = pwdata[1:0];
          mtm = pwdata[2];
          mlk |= pwdata[3];
        end
        if (paddr == PAO_PRELOAD_OFS) nq = pwdata[7:0];
        if (paddr[1:0] == 2'h0 && paddr[11:8] == PAO_NORM_PAGE)
          mc[paddr[7:2]] = pwdata;
        if (paddr[1:0] == 2'h0 && paddr[11:8] == PAO_TEST_PAGE)
          mt[paddr[7:2]] = pwdata[7:0];
      end
      mq = nq;
    end
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(negedge clk) begin
    if (arst_n) begin
      pao_pins_t e;
      for (int k = 0; k < 8; k++) begin
        e.oe[k] = isreg(k) ? ~oe_n : term(k * 8);
        e.o[k] = isreg(k) ? ~mq[k] : ~orsum(k, 1);
      end
      check({17'h0, io_drv}, {17'h0, e});
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [32:0] m);
    logic [32:0] e;
    logic [32:0] got;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the edge where pready is seen high
    do begin
      @(negedge clk);
      e = mread(a);
      @(posedge clk);
      got = {pslverr, prdata};
    end while (pready !== 1'b1);
    if (!w) check(got & m, e & m);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps psel from being set twice in a time step
    @(posedge clk);
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_fail++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] w;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, PAO_CTRL_OFS, 32'h0, '1);
    apb(1'b0, PAO_STAT_OFS, 32'h0, '1);
    apb(1'b0, 12'h00C, 32'h0, '1);
    apb(1'b0, 12'h102, 32'h0, '1);
    // Most combinatorial variant first, so no stale term makes a pin loop
    for (int v = 3; v >= 0; v--) begin
      apb(1'b1, PAO_CTRL_OFS, 32'(v), '1);
      @(posedge clk);
      for (int t = 0; t < 64; t++) begin
        r = $random(seed);
        w = ~((32'h1 << {r[3], 1'b0, r[2:0]}) | (32'h1 << {r[7], 1'b0, r[6:4]})
          | (isreg(t / 8) ? 32'h1 << {r[11], 1'b1, r[10:8]} : 32'h0));
        if (r[15:13] == 3'h0) w = 32'h0;
        apb(1'b1, 12'h100 + 12'(t * 4), w, '1);
      end
      repeat (30) @(posedge clk);
      apb(1'b0, PAO_STAT_OFS, 32'h0, '1);
      apb(1'b1, PAO_PRELOAD_OFS, {24'h0, 8'($random(seed))}, '1);
      apb(1'b0, PAO_PRELOAD_OFS, 32'h0, '1);
    end
    for (int t = 0; t < 64; t++) begin
      r = $random(seed);
      w = {24'h0, ~((8'h1 << r[2:0]) | (8'h1 << r[5:3]))};
      apb(1'b1, 12'h200 + 12'(t * 4), w, '1);
    end
    apb(1'b1, PAO_CTRL_OFS, 32'h4, '1);
    repeat (30) @(posedge clk);
    apb(1'b1, PAO_CTRL_OFS, 32'h0, '1);
    repeat (30) @(posedge clk);
    apb(1'b0, 12'h104, 32'h0, '1);
    apb(1'b1, PAO_CTRL_OFS, 32'h8, '1);
    apb(1'b1, PAO_CTRL_OFS, 32'h0, '1);
    apb(1'b0, PAO_CTRL_OFS, 32'h0, '1);
    apb(1'b0, 12'h104, 32'h0, '1);
    apb(1'b0, 12'h214, 32'h0, '1);
    finish_test();
  end
endmodule
`default_nettype wire
